// >>> verilog/swsc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "swsc_consts.svh"
module swsc_device #(
  parameter int                 BUSY_CYC = `SWSC_BUSY_CYC,
  parameter logic [`SWSC_DATA_BITS-1:0] NV_INIT = `SWSC_NV_INIT
) (
  input  wire logic              clock,
  input  wire logic              rst,
  swsc_if.device                 link,
  input  wire logic              vdd_low,
  output var  swsc_pkg::swsc_data_t setting,
  output var  swsc_pkg::swsc_data_t stored,
  output var  logic              busy
);
  import swsc_pkg::*;

  localparam int TW = $clog2(BUSY_CYC + 1);

  logic [4:0]      pins_s;
  logic            sclk_s;
  logic            cs_s;
  logic            sin_s;
  logic            store_s;
  logic            vlow_s;
  logic            sclk_prev_q;
  logic            rise;
  swsc_dev_state_e state_q;
  logic [2:0]      cnt_q;
  logic [1:0]      addr_q;
  logic            match;
  swsc_data_t      shreg_q;
  logic            dout_q;
  logic            dout_oe_q;
  logic            store_seen_q;
  logic            go;
  swsc_data_t      wr_data_q;
  logic [TW-1:0]   timer_q;
  logic            ready_q;

  // ==========================================================
  // pin sampling
  swsc_sync #(
    .W (5)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({vdd_low, link.store_request, link.serial_in, link.cs,
             link.sclk}),
    .q     (pins_s)
  );

  assign sclk_s  = pins_s[0];
  assign cs_s    = pins_s[1];
  assign sin_s   = pins_s[2];
  assign store_s = pins_s[3];
  assign vlow_s  = pins_s[4];
  assign rise    = sclk_s & ~sclk_prev_q;
  assign match   = (addr_q == `SWSC_ADDR_SEL);
  assign go      = (store_seen_q | store_s) & match;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end

  // ==========================================================
  // frame sequencer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= DEV_IDLE;
      cnt_q   <= 3'h0;
      addr_q  <= 2'h0;
    end
    else if (!cs_s || busy)
    begin
      state_q <= DEV_IDLE;
      cnt_q   <= 3'h0;
    end
    else if (rise)
    begin
      unique case (state_q)
        DEV_IDLE:
        begin
          cnt_q <= 3'h0;
          if (sin_s == `SWSC_START_BIT)
            state_q <= DEV_ADDR;
        end
        DEV_ADDR:
        begin
          addr_q <= {sin_s, addr_q[1]};
          if (cnt_q == `SWSC_ADDR_LAST)
          begin
            cnt_q   <= 3'h0;
            state_q <= DEV_DATA;
          end
          else
            cnt_q <= cnt_q + 3'h1;
        end
        DEV_DATA:
        begin
          if (cnt_q == `SWSC_DATA_LAST)
            state_q <= DEV_APPLY;
          else
            cnt_q <= cnt_q + 3'h1;
        end
        DEV_APPLY:
          state_q <= DEV_GAP;
        DEV_GAP:
          state_q <= DEV_IDLE;
      endcase
    end
  end

  // ==========================================================
  // control register and serial output
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      shreg_q   <= NV_INIT;
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
    end
    else
    begin
      dout_oe_q <= cs_s;
      if (!cs_s)
      begin
        shreg_q <= stored;
        dout_q  <= 1'b0;
      end
      else if (busy)
        dout_q <= 1'b0;
      else if (rise)
      begin
        if (state_q == DEV_ADDR && cnt_q == `SWSC_ADDR_LAST)
          dout_q <= shreg_q[0];
        else if (state_q == DEV_DATA)
        begin
          shreg_q <= {sin_s, shreg_q[`SWSC_DATA_BITS-1:1]};
          dout_q  <= (cnt_q == `SWSC_DATA_LAST) ? 1'b0 : shreg_q[1];
        end
        else if (state_q == DEV_GAP)
          shreg_q <= stored;
      end
    end
  end

  // ==========================================================
  // applied output setting
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      setting <= NV_INIT;
    else if (!cs_s)
      setting <= stored;
    else if (rise && !busy && state_q == DEV_APPLY && match)
      setting <= shreg_q;
  end

  // ==========================================================
  // store request capture
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      store_seen_q <= 1'b0;
    else if (!cs_s || state_q == DEV_IDLE)
      store_seen_q <= 1'b0;
    else if (store_s && (state_q == DEV_ADDR || state_q == DEV_DATA))
      store_seen_q <= 1'b1;
  end

  // ==========================================================
  // nonvolatile write cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stored    <= NV_INIT;
      wr_data_q <= NV_INIT;
      busy      <= 1'b0;
      ready_q   <= 1'b1;
      timer_q   <= '0;
    end
    else if (busy)
    begin
      if (timer_q != '0)
        timer_q <= timer_q - TW'(1);
      else if (rise)
      begin
        stored  <= wr_data_q;
        busy    <= 1'b0;
        ready_q <= 1'b1;
      end
    end
    else if (cs_s && rise && state_q == DEV_APPLY && go && !vlow_s)
    begin
      wr_data_q <= shreg_q;
      busy      <= 1'b1;
      ready_q   <= 1'b0;
      timer_q   <= TW'(BUSY_CYC - 1);
    end
  end

  assign link.serial_out    = dout_q;
  assign link.serial_out_oe = dout_oe_q;
  assign link.ready_flag    = ready_q;
endmodule
`default_nettype wire

// >>> include/swsc_consts.svh
// Summary of operation
// - store request drops ready until write done
// - while busy ignore input, output no data
// - low supply keeps ready high, nothing stored
// - output starts after start and address bits
// - output driven while select high, else floating
// - start, two address, eight data bits in
// - new setting applied cycle after last data bit
// - host raises store after start, before apply edge
// - next frame accepted two clocks after last bit
// - host keeps clock running during store
// - every transfer shifts held contents out
// - read is not destructive, held data reloads from stored value
// - read only: select low before twelfth clock
// - temporary setting holds while select stays high
// - select low restores stored value
// - unstored data discarded two clocks after receipt
// - frame starts with one, bits lsb first
// - output selected by address first one, second zero
// - power-on reset loads stored value, no clock
// - write cycle lasts typically four milliseconds
`ifndef SWSC_CONSTS_SVH
`define SWSC_CONSTS_SVH
`define SWSC_DATA_BITS 8
`define SWSC_START_BIT 1'b1
`define SWSC_ADDR_SEL 2'h1
`define SWSC_ADDR_LAST 3'h1
`define SWSC_DATA_LAST 3'h7
`define SWSC_NV_INIT 8'h80
`define SWSC_CLK_NS 8
`define SWSC_T_BUSY_US 4000
`define SWSC_BUSY_CYC ((`SWSC_T_BUSY_US * 1000) / `SWSC_CLK_NS)
`define SWSC_T_CLKH_NS 500
`define SWSC_HALF_CYC ((`SWSC_T_CLKH_NS + `SWSC_CLK_NS - 1) / `SWSC_CLK_NS)
`define SWSC_EDGE_STORE 4'h1
`define SWSC_EDGE_RD_FIRST 4'h3
`define SWSC_EDGE_RD_LAST 4'hA
`define SWSC_EDGE_D7 4'hB
`define SWSC_EDGE_GAP_DONE 4'hD
`endif

// >>> include/swsc_pkg.sv
`include "swsc_consts.svh"
package swsc_pkg;
  typedef logic [`SWSC_DATA_BITS-1:0] swsc_data_t;
  typedef enum logic [4:0] {
    DEV_IDLE  = 5'h01,
    DEV_ADDR  = 5'h02,
    DEV_DATA  = 5'h04,
    DEV_APPLY = 5'h08,
    DEV_GAP   = 5'h10
  } swsc_dev_state_e;
  typedef enum logic [4:0] {
    HST_IDLE  = 5'h01,
    HST_SETUP = 5'h02,
    HST_SHIFT = 5'h04,
    HST_WAIT  = 5'h08,
    HST_REST  = 5'h10
  } swsc_hst_state_e;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_TEMP  = 2'h1,
    OP_STORE = 2'h2
  } swsc_op_e;
endpackage

// >>> include/swsc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swsc_if;
  logic sclk;
  logic cs;
  logic serial_in;
  logic store_request;
  logic serial_out;
  logic serial_out_oe;
  logic ready_flag;
  modport device (
    input  sclk,
    input  cs,
    input  serial_in,
    input  store_request,
    output serial_out,
    output serial_out_oe,
    output ready_flag
  );
  modport host (
    output sclk,
    output cs,
    output serial_in,
    output store_request,
    input  serial_out,
    input  serial_out_oe,
    input  ready_flag
  );
endinterface
`default_nettype wire

// >>> verilog/swsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module swsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================
  // three stages, change taken once stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/swsc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "swsc_consts.svh"
module swsc_host #(
  parameter int HALF_CYC = `SWSC_HALF_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  swsc_if.host                      link,
  input  wire logic                 cmd_valid,
  input  wire swsc_pkg::swsc_op_e   cmd_op,
  input  wire swsc_pkg::swsc_data_t cmd_data,
  output var  logic                 cmd_ready,
  output var  swsc_pkg::swsc_data_t rd_data,
  output var  logic                 rd_valid,
  output var  logic                 store_busy
);
  import swsc_pkg::*;

  localparam int HW = $clog2(HALF_CYC + 1);

  logic [1:0]           back_s;
  logic                 dout_s;
  logic                 ready_s;
  logic [HW-1:0]        div_q;
  logic                 tick;
  logic                 fall;
  swsc_hst_state_e      state_q;
  swsc_op_e             op_q;
  logic [10:0]          tx_q;
  logic [3:0]           edge_q;
  logic                 sclk_q;
  logic                 cs_q;
  logic                 sin_q;
  logic                 store_request_q;

  // ==========================================================
  // pin sampling
  swsc_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({link.ready_flag, link.serial_out}),
    .q     (back_s)
  );

  assign dout_s  = back_s[0];
  assign ready_s = back_s[1];
  assign tick    = (div_q == '0);
  assign fall    = tick & sclk_q;

  // ==========================================================
  // half period divider
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      div_q <= HW'(HALF_CYC - 1);
    else if (tick)
      div_q <= HW'(HALF_CYC - 1);
    else
      div_q <= div_q - HW'(1);
  end

  // ==========================================================
  // frame sequencer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= HST_IDLE;
      op_q       <= OP_READ;
      tx_q       <= '0;
      edge_q     <= 4'h0;
      sclk_q     <= 1'b0;
      cs_q       <= 1'b0;
      sin_q      <= 1'b0;
      store_request_q     <= 1'b0;
      cmd_ready  <= 1'b1;
      rd_valid   <= 1'b0;
      rd_data    <= '0;
      store_busy <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      unique case (state_q)
        HST_IDLE:
          if (cmd_valid)
          begin
            op_q      <= cmd_op;
            tx_q      <= {cmd_data, 1'b0, 1'b1, `SWSC_START_BIT};
            sin_q     <= `SWSC_START_BIT;
            edge_q    <= 4'h0;
            cmd_ready <= 1'b0;
            cs_q      <= 1'b1;
            state_q   <= cs_q ? HST_SHIFT : HST_SETUP;
          end
        HST_SETUP:
          if (tick)
            state_q <= HST_SHIFT;
        HST_SHIFT:
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (!sclk_q)
              edge_q <= edge_q + 4'h1;
            else
            begin
              tx_q  <= {1'b0, tx_q[10:1]};
              sin_q <= tx_q[1];
              if (edge_q >= `SWSC_EDGE_RD_FIRST &&
                  edge_q <= `SWSC_EDGE_RD_LAST)
                rd_data <= {dout_s, rd_data[`SWSC_DATA_BITS-1:1]};
              if (edge_q == `SWSC_EDGE_STORE && op_q == OP_STORE)
              begin
                store_request_q     <= 1'b1;
                store_busy <= 1'b1;
              end
              if (edge_q == `SWSC_EDGE_D7 && op_q == OP_READ)
              begin
                cs_q     <= 1'b0;
                rd_valid <= 1'b1;
                state_q  <= HST_REST;
              end
              else if (edge_q == `SWSC_EDGE_GAP_DONE)
              begin
                rd_valid <= 1'b1;
                if (op_q == OP_STORE)
                  state_q <= HST_WAIT;
                else
                begin
                  cmd_ready <= 1'b1;
                  state_q   <= HST_IDLE;
                end
              end
            end
          end
        HST_WAIT:
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (fall && ready_s)
            begin
              store_request_q     <= 1'b0;
              cs_q       <= 1'b0;
              store_busy <= 1'b0;
              state_q    <= HST_REST;
            end
          end
        HST_REST:
          if (tick)
          begin
            cmd_ready <= 1'b1;
            state_q   <= HST_IDLE;
          end
      endcase
    end
  end

  assign link.sclk          = sclk_q;
  assign link.cs            = cs_q;
  assign link.serial_in     = sin_q;
  assign link.store_request = store_request_q;
endmodule
`default_nettype wire

// >>> testbench/swsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module swsc_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs,
  input wire logic serial_in,
  input wire logic store_request,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic ready_flag
);
  // ==========================================================
  // link checks
  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (rst);

  oe_on_sel_a : assert property (cs [*8] |-> serial_out_oe)
    else $error("output not driven while selected");
  oe_off_desel_a : assert property (!cs [*8] |-> !serial_out_oe)
    else $error("output still driven while deselected");
  busy_quiet_a : assert property (!ready_flag |-> !serial_out)
    else $error("data on output during write cycle");
  busy_hold_a : assert property (
    $fell(ready_flag) |-> !ready_flag [*8])
    else $error("ready returned too early");
  busy_cause_a : assert property (
    $fell(ready_flag) |-> cs && sclk && store_request)
    else $error("ready dropped without a store edge");
  busy_bound_a : assert property (
    $fell(ready_flag) |-> ##[1:400] ready_flag)
    else $error("write cycle did not end");
  done_on_clk_a : assert property (
    $rose(ready_flag) |-> sclk && cs)
    else $error("write ended without serial clock");
  quiet_start_a : assert property (
    $rose(serial_out_oe) |-> !serial_out)
    else $error("data before address received");
  out_on_rise_a : assert property (
    $changed(serial_out) |-> sclk)
    else $error("output changed away from clock rise");

  // ==========================================================
  // scenario covers
  cover property ($fell(ready_flag));
  cover property ($rose(serial_out_oe));
  cover property ($fell(cs) ##1 !cs);
  cover property ($rose(sclk) && serial_in && cs);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swsc_pkg::*;
  typedef struct {
    swsc_op_e   op;
    swsc_data_t d;
    swsc_data_t rd;
    swsc_data_t set;
    swsc_data_t nv;
  } swsc_row_s;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  swsc_op_e   cmd_op = OP_READ;
  swsc_data_t cmd_data = 8'h00;
  logic       cmd_ready;
  swsc_data_t rd_data;
  logic       rd_valid;
  logic       store_busy;
  swsc_data_t setting;
  swsc_data_t stored;
  logic       busy;
  logic       vdd_low2 = 1'b0;
  swsc_data_t setting2;
  swsc_data_t stored2;
  logic       busy2;
  logic       dropped = 1'b0;
  int         fails = 0;
  int         checks = 0;
  int         cycles = 0;
  swsc_row_s  rows [7];

  // ==========================================================
  // pair under test and a bench-driven second device
  swsc_if link ();
  swsc_if link2 ();
  swsc_host #(.HALF_CYC(16)) swsc_host_i (
    .clock(clock), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .store_busy(store_busy));
  swsc_device #(.BUSY_CYC(200)) swsc_device_i (
    .clock(clock), .rst(rst), .link(link), .vdd_low(1'b0),
    .setting(setting), .stored(stored), .busy(busy));
  swsc_device #(.BUSY_CYC(200)) swsc_device_i2 (
    .clock(clock), .rst(rst), .link(link2), .vdd_low(vdd_low2),
    .setting(setting2), .stored(stored2), .busy(busy2));
  swsc_assertions swsc_assertions_i (
    .clock(clock), .rst(rst), .sclk(link.sclk), .cs(link.cs),
    .serial_in(link.serial_in), .store_request(link.store_request),
    .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe),
    .ready_flag(link.ready_flag));

  always #4 clock = ~clock;

  always @(negedge clock)
    if (link2.ready_flag === 1'b0)
      dropped = 1'b1;

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic run(input swsc_row_s r);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= r.op;
    cmd_data <= r.d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (n = 0; n < 3000 && rd_valid !== 1'b1; n++)
      @(negedge clock);
    if (n == 3000)
      fails++;
    check(rd_data, r.rd, "read data");
    check(store_busy, r.op == OP_STORE, "store busy");
    check(busy, r.op == OP_STORE, "busy");
    for (n = 0; n < 3000 && cmd_ready !== 1'b1; n++)
      @(negedge clock);
    if (n == 3000)
      fails++;
    repeat (4) @(negedge clock);
    check(setting, r.set, "setting");
    check(stored, r.nv, "stored");
  endtask

  // frame bits: start, addr first, addr second, data lsb first
  task automatic bang(input logic [10:0] f, input int late);
    @(posedge clock);
    link2.cs <= 1'b0;
    repeat (32) @(posedge clock);
    link2.cs <= 1'b1;
    dropped = 1'b0;
    for (int k = 0; k < 14; k++)
    begin
      repeat (16) @(posedge clock);
      link2.sclk <= 1'b0;
      link2.serial_in <= (k < 11) ? f[k] : 1'b0;
      repeat (16) @(posedge clock);
      link2.sclk <= 1'b1;
      if (k == late)
        link2.store_request <= 1'b1;
    end
    repeat (16) @(posedge clock);
    link2.sclk <= 1'b0;
    link2.store_request <= 1'b0;
    repeat (32) @(negedge clock);
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    link2.sclk = 1'b0;
    link2.cs = 1'b0;
    link2.serial_in = 1'b0;
    link2.store_request = 1'b0;
    rows[0] = '{OP_STORE, 8'h3C, 8'h80, 8'h3C, 8'h3C};
    rows[1] = '{OP_TEMP, 8'h5A, 8'h3C, 8'h5A, 8'h3C};
    rows[2] = '{OP_TEMP, 8'hA5, 8'h3C, 8'hA5, 8'h3C};
    rows[3] = '{OP_READ, 8'h11, 8'h3C, 8'h3C, 8'h3C};
    rows[4] = '{OP_STORE, 8'hFF, 8'h3C, 8'hFF, 8'hFF};
    rows[5] = '{OP_READ, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    rows[6] = '{OP_STORE, 8'h00, 8'hFF, 8'h00, 8'h00};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    bang({8'h55, 1'b1, 1'b0, 1'b1}, 4);
    check(setting2, 8'h80, "foreign setting");
    check(stored2, 8'h80, "foreign stored");
    $display("address test done");
    bang({8'hA6, 1'b0, 1'b1, 1'b1}, 12);
    check(setting2, 8'hA6, "late setting");
    check(stored2, 8'h80, "late stored");
    check(dropped, 1'b0, "late ready");
    $display("late store test done");
    @(posedge clock);
    vdd_low2 <= 1'b1;
    bang({8'h33, 1'b0, 1'b1, 1'b1}, 4);
    check(dropped, 1'b0, "low supply ready");
    check(stored2, 8'h80, "low supply stored");
    @(posedge clock);
    link2.cs <= 1'b0;
    repeat (32) @(negedge clock);
    check(setting2, 8'h80, "deselect setting");
    $display("low supply test done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(setting, 8'h80, "reset setting");
    check(stored, 8'h80, "reset stored");
    check(link.ready_flag, 1'b1, "reset ready");
    check(link.serial_out_oe, 1'b0, "reset enable");
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
